// ### ipm_pkg.sv
// Package for the idle and power-down mode controller
package ipm_pkg;
  localparam int unsigned POWER_CONTROL_REGISTER_W = 8;
  localparam int unsigned IDLE_BIT = 0;
  localparam int unsigned PDWN_BIT = 1;
  localparam logic [7:0] POWER_CONTROL_REGISTER_RESET = 8'h00;
  localparam int unsigned WAKE_LOW_CYCLES = 1024;
  localparam int unsigned WAKE_CNT_W = 11;

  typedef enum logic [1:0] {
    IPM_RUN = 2'b00,
    IPM_IDLE = 2'b01,
    IPM_PDWN = 2'b10,
    IPM_WAKE = 2'b11
  } ipm_state_t;

  // Strobe pair driven on the external bus
  typedef struct packed {
    logic addr_latch_strobe;
    logic program_store_strobe;
  } ipm_strobe_t;

  // Power control register write from the core
  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } ipm_power_control_register_wr_t;
endpackage : ipm_pkg

// ### ipm_ctrl.sv
// Idle and power-down mode controller
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Setting the idle request bit enters idle mode.
// - Idle freezes the program counter; clock and peripherals keep running.
// - Idle keeps RAM and special registers unchanged.
// - Enabled interrupt or reset ends idle; service start clears idle bit.
// - After service, execution resumes after the idle-entering instruction.
// - Reset in idle or power-down restarts as power-on reset.
// - Setting the power-down request bit enters power-down.
// - Power-down stops the clock; only enabled level external interrupts act.
// - Power-down retains SRAM and special registers.
// - Only level external interrupt or reset ends power-down; clears bit.
// - Low interrupt pin restarts oscillator; must stay low 1024 cycles.
// - Pin returning high runs service, then resumes after entry instruction.
// - Idle holds address latch and program store strobes high.
// - Power-down holds address latch and program store strobes low.
module ipm_ctrl #(
  parameter int unsigned WAKE_CYCLES = ipm_pkg::WAKE_LOW_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ipm_pkg::ipm_power_control_register_wr_t power_control_register_wr,
  input wire ipm_pkg::ipm_strobe_t core_strobe,
  input wire logic irq_pending,
  input wire logic irq_service_start,
  input wire logic ext_irq_n,
  input wire logic ext_irq_en,
  input wire logic ext_irq_level,
  output logic [7:0] power_control_register,
  output logic cpu_halt,
  output logic clk_gate_off,
  output logic osc_enable,
  output logic wake_irq,
  output ipm_pkg::ipm_strobe_t bus_strobe
);
  import ipm_pkg::*;

  // ==========================================================
  // Pin synchroniser
  logic ext_meta_q;
  logic ext_sync_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta_q <= 1'b1;
      ext_sync_q <= 1'b1;
    end else begin
      ext_meta_q <= ext_irq_n;
      ext_sync_q <= ext_meta_q;
    end
  end

  // ==========================================================
  // Decode
  ipm_state_t state_q;
  ipm_state_t state_d;
  logic [7:0] power_control_register_q;
  logic [7:0] power_control_register_d;
  logic [WAKE_CNT_W-1:0] cnt_q;
  logic [WAKE_CNT_W-1:0] cnt_d;
  logic wake_q;
  logic wake_d;
  wire logic idle_req = power_control_register_q[IDLE_BIT];
  wire logic pdwn_req = power_control_register_q[PDWN_BIT];
  wire logic lvl_wake = ext_irq_en & ext_irq_level & ~ext_sync_q;
  wire logic cnt_done = (cnt_q >= WAKE_CNT_W'(WAKE_CYCLES - 1));

  // Register update; service start clears both request bits
  always_comb begin
    power_control_register_d = power_control_register_q;
    if (power_control_register_wr.wr) begin
      power_control_register_d = power_control_register_wr.data;
    end
    if (irq_service_start) begin
      power_control_register_d[IDLE_BIT] = 1'b0;
      power_control_register_d[PDWN_BIT] = 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    wake_d = 1'b0;
    unique case (state_q)
      IPM_RUN: begin
        if (pdwn_req) begin
          state_d = IPM_PDWN;
        end else if (idle_req) begin
          state_d = IPM_IDLE;
        end
      end
      IPM_IDLE: begin
        if (irq_pending) begin
          wake_d = 1'b1;
        end
        if (!idle_req) begin
          state_d = IPM_RUN;
        end
      end
      IPM_PDWN: begin
        cnt_d = '0;
        if (lvl_wake) begin
          state_d = IPM_WAKE;
        end
      end
      IPM_WAKE: begin
        if (!ext_sync_q) begin
          if (!cnt_done) begin
            cnt_d = cnt_q + WAKE_CNT_W'(1);
          end
        end else if (cnt_done) begin
          wake_d = 1'b1;
          if (!pdwn_req) begin
            state_d = IPM_RUN;
          end
        end else begin
          state_d = IPM_PDWN;
        end
      end
    endcase
  end

  // ==========================================================
  // State registers; reset acts as power-on
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= IPM_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_control_register_q <= POWER_CONTROL_REGISTER_RESET;
    end else begin
      power_control_register_q <= power_control_register_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end

  // ==========================================================
  // Output decode
  function automatic logic mode_halts(input ipm_state_t s);
    return (s != IPM_RUN);
  endfunction : mode_halts

  function automatic logic mode_clock_off(input ipm_state_t s);
    return (s == IPM_PDWN) | (s == IPM_WAKE);
  endfunction : mode_clock_off

  function automatic ipm_strobe_t mode_strobes(input ipm_state_t s,
                                               input ipm_strobe_t run_val);
    if (s == IPM_IDLE) begin
      return '1;
    end else if (s == IPM_RUN) begin
      return run_val;
    end
    return '0;
  endfunction : mode_strobes

  wire logic halt_d = mode_halts(state_d);
  wire logic gate_d = mode_clock_off(state_d);
  wire logic osc_d = (state_d != IPM_PDWN);
  wire ipm_strobe_t strobe_d = mode_strobes(state_d, core_strobe);

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_halt <= 1'b0;
    end else begin
      cpu_halt <= halt_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_gate_off <= 1'b0;
    end else begin
      clk_gate_off <= gate_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_enable <= 1'b1;
    end else begin
      osc_enable <= osc_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_strobe <= '1;
    end else begin
      bus_strobe <= strobe_d;
    end
  end

  assign power_control_register = power_control_register_q;
  assign wake_irq = wake_q;
endmodule : ipm_ctrl
`default_nettype wire

// ### ipm_ctrl_chk.sv
// Checker for the power-mode controller
`timescale 1ns/1ps
`default_nettype none
module ipm_ctrl_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ipm_pkg::ipm_power_control_register_wr_t power_control_register_wr,
  input wire logic irq_service_start,
  input wire logic ext_irq_en,
  input wire logic [7:0] power_control_register,
  input wire logic cpu_halt,
  input wire logic clk_gate_off,
  input wire logic osc_enable,
  input wire logic wake_irq,
  input wire ipm_pkg::ipm_strobe_t bus_strobe
);
  import ipm_pkg::*;
  wire logic [7:0] pcr = power_control_register;
  wire logic w = power_control_register_wr.wr && !irq_service_start;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ====
  // Mode checks
  a_idle_write: assert property (w && power_control_register_wr.data == 8'h01 |=> pcr == 8'h01)
    else $error("idle write");
  a_pd_write: assert property (w && power_control_register_wr.data == 8'h02 |=> pcr == 8'h02)
    else $error("pd write");
  a_svc_clears: assert property (irq_service_start |=> pcr[1:0] == 2'b00)
    else $error("bits kept");
  a_idle_halt: assert property ($rose(pcr[0]) && !pcr[1] ##1 !irq_service_start |-> ##1 cpu_halt)
    else $error("no halt");
  a_pd_strobes: assert property (!osc_enable |-> clk_gate_off && bus_strobe == 2'b00)
    else $error("pd outputs");
  a_idle_strobes: assert property (cpu_halt && !clk_gate_off |-> bus_strobe == 2'b11)
    else $error("idle strobes");
  a_pd_refused: assert property (!osc_enable && !ext_irq_en |=> !wake_irq)
    else $error("wake");
  a_reset_state: assert property ($rose(rst_n) |-> pcr == 8'h00 && !cpu_halt)
    else $error("reset");
  c_idle: cover property (cpu_halt && !clk_gate_off);
  c_pd: cover property (!osc_enable);
  c_wake: cover property (wake_irq);
endmodule : ipm_ctrl_chk
bind ipm_ctrl ipm_ctrl_chk i_ipm_ctrl_chk (.clk_sys, .rst_n, .power_control_register_wr,
  .irq_service_start, .ext_irq_en, .power_control_register, .cpu_halt,
  .clk_gate_off, .osc_enable, .wake_irq, .bus_strobe);
`default_nettype wire

// ### ipm_core_model.sv
// Core sequencer model answering wake requests
`timescale 1ns/1ps
`default_nettype none
module ipm_core_model #(parameter int DLY = 2) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wake_irq,
  output var logic irq_service_start
);
  // ====
  // Service start after DLY+1 consecutive wake cycles
  int n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      n <= 0;
      irq_service_start <= 1'b0;
    end else begin
      n <= wake_irq ? n + 1 : 0;
      irq_service_start <= wake_irq && n == DLY;
    end
  end
endmodule : ipm_core_model
`default_nettype wire

// ### idle_powerdown_mode_control_tb.sv
// Testbench for the power-mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module idle_powerdown_mode_control_tb;
  import ipm_pkg::*;
  logic clk_sys, rst_n, irq_pending, svc, ext_irq_n, ext_irq_en;
  logic ext_irq_level;
  logic halt, gate, osc, wake;
  logic [7:0] pcr;
  ipm_power_control_register_wr_t power_control_register_wr;
  ipm_strobe_t bus_strobe;
  int err_total = 0;
  int compares = 0;
  ipm_ctrl #(.WAKE_CYCLES(8)) i_ipm_ctrl (.clk_sys, .rst_n, .power_control_register_wr,
    .core_strobe(2'b10), .irq_pending, .irq_service_start(svc), .ext_irq_n,
    .ext_irq_en, .ext_irq_level, .power_control_register(pcr),
    .cpu_halt(halt), .clk_gate_off(gate), .osc_enable(osc), .wake_irq(wake),
    .bus_strobe);
  ipm_core_model i_ipm_core_model (.clk_sys, .rst_n, .wake_irq(wake),
    .irq_service_start(svc));
  // ====
  // Scenarios
  task stop_test;
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task cyc(input int k);
    repeat (k) @(posedge clk_sys) #1;
  endtask : cyc
  task wr(input logic [7:0] d);
    power_control_register_wr = '{1'b1, d};
    cyc(1);
    power_control_register_wr.wr = 1'b0;
  endtask : wr
  task wm(input logic v);
    int i;
    for (i = 0; i < 3000 && (halt | gate) !== v; i++) cyc(1);
    if (i == 3000) begin err_total++; stop_test(); end
  endtask : wm
  task s_idle;
    wr(8'h01);
    wm(1);
    `CHK("strb", 2'b11, bus_strobe)
    `CHK("reg", 8'h01, pcr)
    `CHK("osc", 1'b1, osc)
    irq_pending = 1'b1;
    cyc(2);
    `CHK("wake", 1'b1, wake)
    wm(0);
    `CHK("reg", 8'h00, pcr)
    `CHK("strb", 2'b10, bus_strobe)
    irq_pending = 1'b0;
  endtask : s_idle
  task s_pd;
    ext_irq_en = 1'b0;
    wr(8'h02);
    wm(1);
    `CHK("strb", 2'b00, bus_strobe)
    ext_irq_n = 1'b0;
    cyc(20);
    `CHK("osc", 1'b0, osc)
    ext_irq_en = 1'b1;
    ext_irq_level = 1'b0;
    cyc(20);
    `CHK("osc", 1'b0, osc)
    ext_irq_n = 1'b1;
    ext_irq_level = 1'b1;
    cyc(3);
    ext_irq_n = 1'b0;
    cyc(4);
    ext_irq_n = 1'b1;
    cyc(10);
    `CHK("osc", 1'b0, osc)
    ext_irq_n = 1'b0;
    cyc(14);
    ext_irq_n = 1'b1;
    wm(0);
    `CHK("reg", 8'h00, pcr)
  endtask : s_pd
  task s_reset;
    wr(8'h03);
    wm(1);
    `CHK("gate", 1'b1, gate)
    rst_n = 1'b0;
    cyc(1);
    `CHK("strb", 2'b11, bus_strobe)
    rst_n = 1'b1;
    cyc(2);
    `CHK("reg", 8'h00, pcr)
    `CHK("halt", 1'b0, halt)
    `CHK("strb", 2'b10, bus_strobe)
  endtask : s_reset
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_n, irq_pending, ext_irq_en, power_control_register_wr} = '0;
    ext_irq_n = 1'b1;
    ext_irq_level = 1'b1;
    cyc(12);
    rst_n = 1'b1;
    s_idle();
    s_pd();
    s_reset();
    stop_test();
  end
endmodule : idle_powerdown_mode_control_tb
`default_nettype wire
